//--- design/tss_count_mem.v
// Per-drive write error counter memory with registered read
`timescale 1ns/100ps
`default_nettype none
module tss_count_mem #(
    parameter AW = 3,                  // Drive address width
    parameter DW = 8                   // Counter width
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          we,           // Write enable
    input  wire [AW-1:0] waddr,        // Write drive
    input  wire [DW-1:0] wdata,        // Write value
    input  wire [AW-1:0] raddr,        // Read drive
    output reg  [DW-1:0] rdata         // Registered read data
);
    reg [DW-1:0] mem_q [0:(1<<AW)-1];  // One counter per drive
    integer i;

    // Counters clear on reset so a fresh controller reports zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem_q[i] <= {DW{1'b0}};
            end
            rdata <= {DW{1'b0}};
        end else begin
            if (we) begin
                mem_q[waddr] <= wdata;
            end
            rdata <= mem_q[raddr];
        end
    end
endmodule // tss_count_mem
`default_nettype wire

//--- design/tss_defines.vh
// Constants for the tape sense status bank
`ifndef TSS_DEFINES_VH
`define TSS_DEFINES_VH
// Sense byte indices (register address = byte number)
`define TSS_B10 5'h0A
`define TSS_B11 5'h0B
`define TSS_B12 5'h0C
`define TSS_B13 5'h0D
`define TSS_B15 5'h0F
`define TSS_B16 5'h10
`define TSS_B17 5'h11
`define TSS_B18 5'h12
`define TSS_B19 5'h13
`define TSS_B21 5'h15
`define TSS_B22 5'h16
`define TSS_B23 5'h17
// Control register (written by controller logic, not sense data)
`define TSS_CTRL 5'h1F
// Write error thresholds
`define TSS_THR_GCR 8'h60
`define TSS_THR_PE  8'h20
// Gain calibration bucket limits
`define TSS_GC_14 4'hE
`define TSS_GC_12 4'hC
`define TSS_GC_10 4'hA
`define TSS_GC_8  4'h8
// Reset value of sense bytes
`define TSS_ZERO8 8'h00
`endif

//--- design/tss_sense_bank.v
// Extended sense bytes 10..23 of a tape controller
`timescale 1ns/100ps
`default_nettype none
`include "tss_defines.vh"
// Functional notes
// - Byte10 bits0-2: tag handshake failures
// - Byte10 bit3: write saw no block
// - Byte10 bit4: dynamic reversal faults
// - Byte10 bit5: tacho start failure
// - Byte10 bit7: write velocity check
// - Byte10 bit6 always zero
// - Byte11 bit0: overlong block overrun
// - Byte11 bit1: lost position, skip-file
// - Byte11 bit2: abnormal tag-in response
// - Byte11 bit3: local register parity
// - Byte11 bits4,6: microprogram error, trap
// - Byte11 bits5,7: controller, drive ROM parity
// - Byte12 mirrors drive internal state
// - Byte12 bit4: low slice fallback
// - Byte12 bit7: tape mark on spacing
// - Per-drive write error counter, cleared
// - Prime error marker above threshold
// - Bytes15,16: features and serial number
// - Bytes17,18: features and change levels
// - Byte18 gain count buckets, GROUP_CODED_DENSITY only
// - Byte19 reversed device-end map
// - Counter overflow sets overflow flag
module tss_sense_bank #(
    parameter [3:0] CU_ENGINEERING_CHANGE_LEVEL = 4'h0,  // Arbitrary change level value
    parameter       NDRV        = 8      // Drive count
) (
    input  wire        clk,
    input  wire        rst,
    // Register port
    input  wire [4:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata,
    // Controller event pulses
    input  wire        ev_status_tag_fail,
    input  wire        ev_command_tag_fail,
    input  wire        ev_control_tag_fail,
    input  wire        ev_no_block,
    input  wire        ev_reverse_overrun,
    input  wire        ev_bot_timeout,
    input  wire        ev_tacho_fail,
    input  wire        ev_velocity_fail,
    input  wire        ev_overlong_block,
    input  wire        ev_position_lost,
    input  wire        ev_skip_no_mark,
    input  wire        ev_tag_in_abnormal,
    input  wire        ev_reg_parity,
    input  wire        ev_microprogram_error,
    input  wire        ev_control_unit_rom_parity,
    input  wire        ev_microprogram_trap,
    input  wire        ev_tape_drive_rom_parity,
    input  wire        ev_low_slice,
    input  wire        ev_tape_mark,
    input  wire        ev_write_error,
    input  wire        ev_count_clear,
    input  wire        ev_device_end,
    input  wire [2:0]  ev_device_end_drive,
    input  wire        sense_clear,
    // Drive status levels (already in clock domain)
    input  wire [2:0]  sel_drive,
    input  wire        drv_erase_on,
    input  wire        drv_active,
    input  wire        drv_backward,
    input  wire        drv_write_on,
    input  wire        drv_high_speed,
    input  wire        drv_inner_1600,
    input  wire        drv_group_coded_density,
    input  wire        drv_high_speed_feat,
    input  wire        drv_skip_file_feat,
    input  wire [11:0] drv_serial,
    input  wire [3:0]  drv_engineering_change_level,
    input  wire [35:0] drv_gain_calibration,
    input  wire [7:0]  drv_error_code,
    input  wire [7:0]  fru_hint_a,
    input  wire [7:0]  fru_hint_b,
    input  wire        cu_two_channel_feat,
    input  wire        cu_800_feat,
    // Results
    output reg         marker_prime,
    output reg         count_overflow
);
    reg  [7:0]  b10_q;        // Tag and motion faults
    reg  [7:0]  b11_q;        // Overrun and parity faults
    reg  [1:0]  b12_q;        // Sticky bits 4 and 7 of byte 12
    reg  [7:0]  dev_end_q;    // Device end map by drive number
    reg  [7:0]  cnt_d;        // Next counter value
    reg         cnt_we;       // Counter update
    reg  [7:0]  rd_d;         // Read mux
    wire [7:0]  cnt_rd;       // Selected drive counter
    wire [7:0]  b12_w;
    wire [3:0]  gc_w;
    wire [7:0]  dev_end_rev;
    integer     k;

    // Does any 4-bit track count lie in [lo, lo+1]
    function bucket;
        input [35:0] cnt;
        input [3:0]  lo;
        integer j;
        begin
            bucket = 1'b0;
            for (j = 0; j < 9; j = j + 1) begin
                if (cnt[j*4+1 +: 3] == lo[3:1]) begin
                    bucket = 1'b1;
                end
            end
        end
    endfunction

    // Sticky fault bits; event beats clear in same cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            b10_q <= `TSS_ZERO8;
            b11_q <= `TSS_ZERO8;
            b12_q <= 2'b00;
        end else begin
            b10_q <= (sense_clear ? `TSS_ZERO8 : b10_q) | {
                ev_velocity_fail,
                1'b0,
                ev_tacho_fail,
                ev_reverse_overrun | ev_bot_timeout,
                ev_no_block,
                ev_control_tag_fail,
                ev_command_tag_fail,
                ev_status_tag_fail};
            b11_q <= (sense_clear ? `TSS_ZERO8 : b11_q) | {
                ev_tape_drive_rom_parity,
                ev_microprogram_trap,
                ev_control_unit_rom_parity,
                ev_microprogram_error,
                ev_reg_parity,
                ev_tag_in_abnormal,
                ev_position_lost | ev_skip_no_mark,
                ev_overlong_block | ev_skip_no_mark};
            b12_q <= (sense_clear ? 2'b00 : b12_q) | {ev_tape_mark, ev_low_slice};
        end
    end

    // Device end flags; set wins over drive-selected clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_end_q <= `TSS_ZERO8;
        end else begin
            for (k = 0; k < NDRV; k = k + 1) begin
                if (ev_device_end && ev_device_end_drive == k) begin
                    dev_end_q[k] <= 1'b1;
                end else if (sense_clear && sel_drive == k) begin
                    dev_end_q[k] <= 1'b0;
                end
            end
        end
    end

    // Counter update; clear by rewind/unload/read backward wins
    always @* begin
        cnt_we = ev_count_clear | ev_write_error;
        cnt_d  = `TSS_ZERO8;
        if (!ev_count_clear && ev_write_error) begin
            cnt_d = (cnt_rd == 8'hFF) ? cnt_rd : cnt_rd + 8'h01;
        end
    end

    // Counters live in a small memory; read follows selected drive
    tss_count_mem #(.AW(3), .DW(8)) u_mem (
        .clk   (clk),
        .rst   (rst),
        .we    (cnt_we),
        .waddr (sel_drive),
        .wdata (cnt_d),
        .raddr (sel_drive),
        .rdata (cnt_rd)
    );

    // Marker priming and overflow flag
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            marker_prime   <= 1'b0;
            count_overflow <= 1'b0;
        end else begin
            marker_prime <= drv_group_coded_density ? (cnt_rd > `TSS_THR_GCR)
                                                    : (cnt_rd > `TSS_THR_PE);
            if (ev_write_error && !ev_count_clear && cnt_rd == 8'hFF) begin
                count_overflow <= 1'b1;
            end else if (sense_clear || ev_count_clear) begin
                count_overflow <= 1'b0;
            end
        end
    end

    assign b12_w = {b12_q[1], drv_inner_1600, drv_high_speed, b12_q[0],
                    drv_write_on, drv_backward, drv_active, drv_erase_on};
    // Buckets only meaningful in group coded density
    assign gc_w  = drv_group_coded_density ?
                   {bucket(drv_gain_calibration, `TSS_GC_8),
                    bucket(drv_gain_calibration, `TSS_GC_10),
                    bucket(drv_gain_calibration, `TSS_GC_12),
                    bucket(drv_gain_calibration, `TSS_GC_14)} : 4'h0;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_rev
            assign dev_end_rev[g] = dev_end_q[7-g];
        end
    endgenerate

    // Read mux; writes are ignored entirely
    always @* begin
        case (addr)
            `TSS_B10: rd_d = b10_q;
            `TSS_B11: rd_d = b11_q;
            `TSS_B12: rd_d = b12_w;
            `TSS_B13: rd_d = cnt_rd;
            `TSS_B15: rd_d = {drv_serial[11:8], 2'b00, drv_skip_file_feat, drv_high_speed_feat};
            `TSS_B16: rd_d = drv_serial[7:0];
            `TSS_B17: rd_d = {CU_ENGINEERING_CHANGE_LEVEL, 2'b00, cu_800_feat, cu_two_channel_feat};
            `TSS_B18: rd_d = {drv_engineering_change_level, gc_w};
            `TSS_B19: rd_d = dev_end_rev;
            `TSS_B21: rd_d = drv_error_code;
            `TSS_B22: rd_d = fru_hint_a;
            `TSS_B23: rd_d = fru_hint_b;
            default:  rd_d = `TSS_ZERO8;
        endcase
    end

    // Read data valid only in the cycle after a read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= `TSS_ZERO8;
        end else begin
            rdata <= rd ? rd_d : `TSS_ZERO8;
        end
    end
endmodule // tss_sense_bank
`default_nettype wire

//--- tb/tss_drive_model.sv
// Model of the attached tape drives: identity and gain levels of the selected drive
`timescale 1ns/100ps
`default_nettype none
module tss_drive_model (
    input  wire logic [2:0]  sel_drive,
    output logic      [11:0] drv_serial,
    output logic      [3:0]  drv_engineering_change_level,
    output logic             drv_high_speed_feat,
    output logic             drv_skip_file_feat,
    output logic      [35:0] drv_gain_calibration
);
    // Serial carries the drive number, so a stale select shows up in the serial bytes
    assign drv_serial = {1'b1, sel_drive, 8'hA5};
    assign drv_engineering_change_level = 4'h6;
    assign drv_high_speed_feat = 1'b1;
    assign drv_skip_file_feat = sel_drive[0];
    // Track 0 at 14 and track 8 at 8; the buckets in between stay empty
    assign drv_gain_calibration = 36'h80000000E;
endmodule // tss_drive_model
`default_nettype wire

//--- tb/tss_sense_bank_chk.sv
// Port checker for the tape sense status bank
`timescale 1ns/100ps
`default_nettype none
module tss_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [4:0]  addr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        ev_status_tag_fail,
    input wire logic        ev_device_end,
    input wire logic [2:0]  ev_device_end_drive,
    input wire logic        sense_clear,
    input wire logic        ev_count_clear,
    input wire logic        drv_active,
    input wire logic [11:0] drv_serial,
    input wire logic        count_overflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00) else $error("read data not zero");
    AST_HOLE: assert property (rd && (addr == 5'h0E || addr == 5'h14) |=> rdata == 8'h00)
        else $error("undefined byte not zero");
    AST_SPARE: assert property (rd && addr == 5'h0A |=> !rdata[6]) else $error("spare bit set");
    AST_STAT_TAG: assert property (ev_status_tag_fail ##1 !sense_clear ##1 (rd && addr == 5'h0A) |=> rdata[0])
        else $error("status tag failure lost");
    AST_MIRROR: assert property (rd && addr == 5'h0C |=> rdata[1] == $past(drv_active))
        else $error("drive action not mirrored");
    AST_SERIAL: assert property (rd && addr == 5'h10 |=> {4'h0, rdata} == ($past(drv_serial) & 12'h0FF))
        else $error("serial low byte wrong");
    AST_DEV_END: assert property (ev_device_end && ev_device_end_drive == 3'h0
        ##1 !sense_clear ##1 !sense_clear ##1 (rd && addr == 5'h13) |=> rdata[7]) else $error("device end of drive 0 lost");
    // Counter clear of the selected drive also drops the flag
    AST_OVF_HOLD: assert property (count_overflow && !sense_clear && !ev_count_clear |=> count_overflow)
        else $error("overflow flag dropped");
    // Main scenarios reached
    COV_TAG: cover property (ev_status_tag_fail);
    COV_OVF: cover property (count_overflow);
    COV_MAP: cover property (rd && addr == 5'h13);
endmodule // tss_chk
bind tss_sense_bank tss_chk u_chk (.*);
`default_nettype wire

//--- tb/tss_sense_bank_tb.sv
// Self-checking bench for the tape sense status bank
`timescale 1ns/100ps
`default_nettype none
module tss_sense_bank_tb;
    logic        clk, rst, wr, rd, sense_clear, ev_write_error, ev_count_clear, ev_device_end;
    logic        drv_group_coded_density, cu_two_channel_feat, cu_800_feat, marker_prime, count_overflow;
    logic        drv_high_speed_feat, drv_skip_file_feat;
    logic [2:0]  sel_drive, ev_device_end_drive;
    logic [4:0]  addr;
    logic [7:0]  wdata, rdata, drv_error_code, fru_hint_a, fru_hint_b, d, b10, b11, b12;
    logic [11:0] drv_serial;
    logic [3:0]  drv_engineering_change_level;
    logic [35:0] drv_gain_calibration;
    logic [18:0] ev;        // Event pulses, one bit per fault source
    logic [5:0]  lv;        // Drive state levels mirrored into byte 12
    int          error_cnt, n_checks;
    // Rows: drive levels, byte number, expected byte
    logic [18:0] rows [13] = '{{6'h25, 5'h0C, 8'h45}, {6'h1A, 5'h0C, 8'h2A}, {6'h00, 5'h0D, 8'h00},
        {6'h00, 5'h0E, 8'h00}, {6'h00, 5'h0F, 8'h81}, {6'h00, 5'h10, 8'hA5}, {6'h00, 5'h11, 8'h51},
        {6'h00, 5'h12, 8'h69}, {6'h00, 5'h14, 8'h00}, {6'h00, 5'h15, 8'h3C}, {6'h00, 5'h16, 8'h11},
        {6'h00, 5'h17, 8'h22}, {6'h00, 5'h09, 8'h00}};
    // Expected {byte12 sticky bits, byte11, byte10} per event bit
    logic [23:0] evt [19] = '{24'h000001, 24'h000002, 24'h000004, 24'h000008, 24'h000010, 24'h000010,
        24'h000020, 24'h000080, 24'h000100, 24'h000200, 24'h000300, 24'h000400, 24'h000800, 24'h001000,
        24'h002000, 24'h004000, 24'h008000, 24'h100000, 24'h800000};
    tss_drive_model u_drv (.*);
    tss_sense_bank #(.CU_ENGINEERING_CHANGE_LEVEL(4'h5)) dut (.*, .ev_status_tag_fail(ev[0]), .ev_command_tag_fail(ev[1]),
        .ev_control_tag_fail(ev[2]), .ev_no_block(ev[3]), .ev_reverse_overrun(ev[4]), .ev_bot_timeout(ev[5]),
        .ev_tacho_fail(ev[6]), .ev_velocity_fail(ev[7]), .ev_overlong_block(ev[8]), .ev_position_lost(ev[9]),
        .ev_skip_no_mark(ev[10]), .ev_tag_in_abnormal(ev[11]), .ev_reg_parity(ev[12]),
        .ev_microprogram_error(ev[13]), .ev_control_unit_rom_parity(ev[14]), .ev_microprogram_trap(ev[15]),
        .ev_tape_drive_rom_parity(ev[16]), .ev_low_slice(ev[17]), .ev_tape_mark(ev[18]),
        .drv_erase_on(lv[0]), .drv_active(lv[1]), .drv_backward(lv[2]), .drv_write_on(lv[3]),
        .drv_high_speed(lv[4]), .drv_inner_1600(lv[5]));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One read strobe; data stands in the following cycle only
    task automatic rd8(input logic [4:0] a, output logic [7:0] q);
        @(posedge clk) addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 q = rdata;
    endtask
    // Write errors spaced well apart to respect the update latency
    // Recovery between errors backspaces, never reads backward, so no count clear here
    task automatic inc(input int n);
        repeat (n) begin
            @(posedge clk) ev_write_error <= 1'b1;
            @(posedge clk) ev_write_error <= 1'b0;
            repeat (3) @(posedge clk);
        end
        #1;
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog well beyond the roughly 1700 cycles the run needs
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
    initial begin
        {rd, wr, sense_clear, ev_write_error, ev_count_clear, ev_device_end, ev, lv, addr, wdata} = '0;
        {sel_drive, ev_device_end_drive, cu_800_feat} = '0;
        {drv_group_coded_density, cu_two_channel_feat} = 2'h3;
        {drv_error_code, fru_hint_a, fru_hint_b} = 24'h3C1122;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1 chk({marker_prime, count_overflow}, 24'h0);
        foreach (rows[i]) begin
            lv <= rows[i][18:13];
            rd8(rows[i][12:8], d);
            chk(d, rows[i][7:0]);
        end
        // Each fault alone after a clear, with a host write that must not stick
        foreach (evt[i]) begin
            sense_clear <= 1'b1;
            @(posedge clk) sense_clear <= 1'b0;
            {wr, addr, wdata} <= {1'b1, 5'h0A, 8'hFF};
            @(posedge clk) wr <= 1'b0;
            @(posedge clk) ev[i] <= 1'b1;
            @(posedge clk) ev <= '0;
            rd8(5'h0A, b10);
            rd8(5'h0B, b11);
            rd8(5'h0C, b12);
            chk({b12 & 8'h90, b11, b10}, evt[i]);
        end
        sel_drive <= 3'h2;
        inc(96);
        chk(marker_prime, 24'h0);
        inc(1);
        chk(marker_prime, 24'h1);
        inc(159);
        chk(count_overflow, 24'h1);
        rd8(5'h0D, d);
        chk(d, 24'hFF);
        drv_group_coded_density <= 1'b0;
        sel_drive <= 3'h1;
        rd8(5'h12, d);
        chk(d, 24'h60);
        inc(32);
        chk(marker_prime, 24'h0);
        inc(1);
        chk(marker_prime, 24'h1);
        @(posedge clk) ev_count_clear <= 1'b1;
        @(posedge clk) ev_count_clear <= 1'b0;
        rd8(5'h0D, d);
        chk(d, 24'h0);
        sel_drive <= 3'h2;
        rd8(5'h0D, d);
        chk(d, 24'hFF);
        // Two device ends back to back, far ends of the reversed map
        @(posedge clk) ev_device_end <= 1'b1;
        @(posedge clk) ev_device_end_drive <= 3'h7;
        @(posedge clk) ev_device_end <= 1'b0;
        rd8(5'h13, d);
        chk(d, 24'h81);
        // Reset in mid-run drops the sticky flags at once
        rst = 1'b1;
        #1 chk({marker_prime, count_overflow}, 24'h0);
        @(posedge clk) rst <= 1'b0;
        rd8(5'h0D, d);
        chk(d, 24'h0);
        rd8(5'h13, d);
        chk(d, 24'h0);
        final_report();
    end
endmodule // tss_sense_bank_tb
`default_nettype wire
